// ---- core/aeg_core.sv ----
`timescale 1ns/1ns
// Summary of operation
// - Attack ramps level to full at rate from 0..99; zero is instant.
// - After peak, level falls toward sustain level at decay rate.
// - Sustain at maximum skips decay, peak goes straight to sustain.
// - Note release enters release, ramping to zero at release rate.
// - Delay stage waits its time before attack; zero starts attack at once.
// - Delay above 99 holds in delay until key release, then continues.
// - Hold mode forces run-to-completion regardless of trigger mode.
// - Sustain lowers level at sustain-decay rate; 99 holds, 0 drops at once.
// - Normal mode: new note continues, release moves straight to release.
// - Run-to-completion finishes all stages despite early release.
// - Restart sends envelope to start of cycle on every new note.
// - Four trigger modes from restart and run-to-completion options.
// - Restart plus run-to-completion restarts and finishes whole cycle.
// - Mono legato retriggers only when restart is selected.
// - Time tracking speeds later segments for high keys, x2 per two octaves.
// - Pedal held, fast settings: note release jumps at once to release.
// - Pedal held, release during attack jumps to sustain-decay segment.
// - Pedal held, release in delay parks at zero unless run-to-completion.
// - Pedal response off ignores sustain pedal entirely.
// - Output scaled by level 0..99; zero gives no output.
// - Envelope always applied at full depth; no depth control.
module aeg_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Note controller events
  input wire logic sample_tick_i,
  input wire logic note_on_i,
  input wire logic note_off_i,
  input wire logic legato_i,
  input wire logic [6:0] key_i,
  input wire logic pedal_i,
  input wire logic mono_i,
  // Time and level settings
  input wire logic [6:0] delay_i,
  input wire logic [6:0] attack_i,
  input wire logic [6:0] decay_i,
  input wire logic [6:0] sustain_i,
  input wire logic [6:0] sus_decay_i,
  input wire logic [6:0] release_i,
  input wire logic [6:0] level_i,
  // Options
  input wire logic restart_i,
  input wire logic freerun_i,
  input wire logic time_track_i,
  input wire logic pedal_resp_i,
  // Envelope result
  output logic [15:0] amplitude_o,
  output logic [2:0] stage_o,
  output logic active_o
);

  aeg_pkg::aeg_stage_t stage_reg, stage_next;
  logic [15:0] level_reg, level_next, phase_reg, phase_next;
  logic [15:0] amp_reg, inc, sus_lvl, gain;
  logic key_down_reg, gate_reg, active_reg;
  logic [6:0] rate_sel;
  logic track_sel, gate, gate_fall, key_off, ped_off;
  logic hold_mode, freerun_eff, sus_full, fast_cfg, start_ev, running;
  logic [31:0] prod;

  // ************************************************************
  // Note gate and option decode
  // ************************************************************
  // Pedal gated off
  assign gate = key_down_reg | (pedal_resp_i & pedal_i);
  assign gate_fall = gate_reg & ~gate;
  assign key_off = note_off_i & key_down_reg;
  assign ped_off = key_off & pedal_resp_i & pedal_i;
  assign hold_mode = delay_i > aeg_pkg::PARAM_MAX;
  assign freerun_eff = freerun_i | hold_mode;
  assign sus_full = sustain_i == aeg_pkg::PARAM_MAX;
  assign fast_cfg = (delay_i == aeg_pkg::PARAM_MIN)
                    && (attack_i == aeg_pkg::PARAM_MIN)
                    && ((decay_i == aeg_pkg::PARAM_MIN) || sus_full);
  assign sus_lvl = 16'(sustain_i * aeg_pkg::LVL_STEP);
  assign running = (stage_reg != aeg_pkg::S_IDLE)
                   && (stage_reg != aeg_pkg::S_RELEASE);
  assign start_ev = note_on_i & (restart_i
                    | (~(mono_i & legato_i) & ~running));

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      key_down_reg <= 1'b0;
      gate_reg <= 1'b0;
    end
    else
    begin
      key_down_reg <= note_on_i | (key_down_reg & ~note_off_i);
      gate_reg <= gate;
    end
  end

  // ************************************************************
  // Rate lookup for the current stage
  // ************************************************************
  always_comb
  begin
    rate_sel = release_i;
    case (stage_reg)
      aeg_pkg::S_DELAY: rate_sel = delay_i;
      aeg_pkg::S_ATTACK: rate_sel = attack_i;
      aeg_pkg::S_DECAY: rate_sel = decay_i;
      aeg_pkg::S_SUSTAIN: rate_sel = sus_decay_i;
      default: rate_sel = release_i;
    endcase
  end
  assign track_sel = time_track_i && (stage_reg == aeg_pkg::S_DECAY
                     || stage_reg == aeg_pkg::S_SUSTAIN
                     || stage_reg == aeg_pkg::S_RELEASE);
  aeg_rate #(.IW(16)) u_rate (
    .param_i(rate_sel),
    .key_i(key_i),
    .track_i(track_sel),
    .inc_o(inc)
  );

  // ************************************************************
  // Stage sequencing
  // ************************************************************
  always_comb
  begin
    stage_next = stage_reg;
    level_next = level_reg;
    phase_next = phase_reg;
    if (sample_tick_i)
    begin
      case (stage_reg)
        aeg_pkg::S_DELAY:
        begin
          if (!hold_mode && phase_reg >= aeg_pkg::LVL_MAX - inc)
            stage_next = aeg_pkg::S_ATTACK;
          else if (!hold_mode)
            phase_next = phase_reg + inc;
        end
        aeg_pkg::S_ATTACK:
        begin
          if (level_reg >= aeg_pkg::LVL_MAX - inc)
          begin
            level_next = aeg_pkg::LVL_MAX;
            stage_next = sus_full ? aeg_pkg::S_SUSTAIN : aeg_pkg::S_DECAY;
          end
          else
            level_next = level_reg + inc;
        end
        aeg_pkg::S_DECAY:
        begin
          if ({1'b0, level_reg} <= {1'b0, sus_lvl} + {1'b0, inc})
          begin
            level_next = sus_lvl;
            stage_next = aeg_pkg::S_SUSTAIN;
          end
          else
            level_next = level_reg - inc;
        end
        aeg_pkg::S_SUSTAIN:
        begin
          if (sus_decay_i == aeg_pkg::PARAM_MAX)
            level_next = level_reg;
          else if ((sus_decay_i == aeg_pkg::PARAM_MIN) || (level_reg <= inc))
            level_next = aeg_pkg::LVL_ZERO;
          else
            level_next = level_reg - inc;
        end
        aeg_pkg::S_RELEASE:
        begin
          if (level_reg <= inc)
          begin
            level_next = aeg_pkg::LVL_ZERO;
            stage_next = aeg_pkg::S_IDLE;
          end
          else
            level_next = level_reg - inc;
        end
        aeg_pkg::S_PARK: level_next = aeg_pkg::LVL_ZERO;
        default: level_next = level_reg;
      endcase
    end
    if (start_ev)
    begin
      if (restart_i)
        level_next = aeg_pkg::LVL_ZERO;
      stage_next = (delay_i == aeg_pkg::PARAM_MIN) ? aeg_pkg::S_ATTACK
                                                    : aeg_pkg::S_DELAY;
      phase_next = aeg_pkg::LVL_ZERO;
    end
    else if (running && hold_mode && key_off
             && stage_reg == aeg_pkg::S_DELAY)
      stage_next = aeg_pkg::S_ATTACK;
    else if (running && ped_off)
    begin
      if (fast_cfg)
        stage_next = aeg_pkg::S_RELEASE;
      else if (stage_reg == aeg_pkg::S_ATTACK)
        stage_next = aeg_pkg::S_SUSTAIN;
      else if (stage_reg == aeg_pkg::S_DELAY && !freerun_eff)
      begin
        stage_next = aeg_pkg::S_PARK;
        level_next = aeg_pkg::LVL_ZERO;
      end
    end
    else if (running && gate_fall && !freerun_eff)
      stage_next = aeg_pkg::S_RELEASE;
    else if (stage_reg == aeg_pkg::S_SUSTAIN && !gate && freerun_eff)
      stage_next = aeg_pkg::S_RELEASE;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stage_reg <= aeg_pkg::S_IDLE;
      level_reg <= aeg_pkg::LVL_ZERO;
      phase_reg <= aeg_pkg::LVL_ZERO;
    end
    else
    begin
      stage_reg <= stage_next;
      level_reg <= level_next;
      phase_reg <= phase_next;
    end
  end

  // ************************************************************
  // Output level
  // ************************************************************
  assign gain = 16'(level_i * aeg_pkg::LVL_STEP);
  assign prod = level_reg * gain;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      amp_reg <= aeg_pkg::LVL_ZERO;
      active_reg <= 1'b0;
    end
    else
    begin
      amp_reg <= prod[31:16];
      active_reg <= stage_next != aeg_pkg::S_IDLE;
    end
  end

  assign amplitude_o = amp_reg;
  assign stage_o = stage_reg;
  assign active_o = active_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  instant_attack_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    stage_reg == aeg_pkg::S_ATTACK && attack_i == aeg_pkg::PARAM_MIN
    && sample_tick_i && !note_on_i && !note_off_i
    |=> level_reg == aeg_pkg::LVL_MAX)
    else $error("instant attack did not reach full level");
  decay_floor_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    stage_reg == aeg_pkg::S_DECAY && $stable(sustain_i)
    |=> stage_reg != aeg_pkg::S_DECAY || level_reg >= sus_lvl)
    else $error("decay went below sustain level");
  skip_decay_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    stage_reg == aeg_pkg::S_ATTACK ##1 stage_reg == aeg_pkg::S_DECAY
    |-> $past(sustain_i) != aeg_pkg::PARAM_MAX)
    else $error("decay entered with sustain at maximum");
  release_end_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    stage_reg == aeg_pkg::S_RELEASE && level_reg == aeg_pkg::LVL_ZERO
    && sample_tick_i && !note_on_i
    |=> stage_reg == aeg_pkg::S_IDLE)
    else $error("release did not end at zero");
  zero_delay_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    start_ev && delay_i == aeg_pkg::PARAM_MIN
    |=> stage_reg == aeg_pkg::S_ATTACK)
    else $error("zero delay did not start attack");
  hold_wait_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    stage_reg == aeg_pkg::S_DELAY && hold_mode && !note_off_i
    |=> stage_reg == aeg_pkg::S_DELAY)
    else $error("hold delay left without key release");
  sus_drop_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    stage_reg == aeg_pkg::S_SUSTAIN && sus_decay_i == aeg_pkg::PARAM_MIN
    && sample_tick_i && !note_on_i
    |=> level_reg == aeg_pkg::LVL_ZERO)
    else $error("zero sustain decay did not drop to zero");
  normal_release_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    gate_fall && !freerun_eff && !note_on_i && !note_off_i
    && (stage_reg == aeg_pkg::S_DECAY || stage_reg == aeg_pkg::S_SUSTAIN)
    |=> stage_reg == aeg_pkg::S_RELEASE)
    else $error("normal mode did not release");
  freerun_keep_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    freerun_eff && stage_reg == aeg_pkg::S_DECAY && !note_on_i
    && !ped_off
    |=> stage_reg != aeg_pkg::S_RELEASE)
    else $error("freerun released during decay");
  restart_zero_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    note_on_i && restart_i |=> level_reg == aeg_pkg::LVL_ZERO)
    else $error("restart did not clear level");
  level_off_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    level_i == aeg_pkg::PARAM_MIN |=> amplitude_o == aeg_pkg::LVL_ZERO)
    else $error("zero level gave output");

endmodule

// ---- core/aeg_pkg.sv ----
package aeg_pkg;

  // ************************************************************
  // Envelope stages
  // ************************************************************
  typedef enum logic [2:0] {
    S_IDLE    = 3'h0,
    S_DELAY   = 3'h1,
    S_ATTACK  = 3'h2,
    S_DECAY   = 3'h3,
    S_SUSTAIN = 3'h4,
    S_RELEASE = 3'h5,
    S_PARK    = 3'h6
  } aeg_stage_t;

  // ************************************************************
  // Parameter ranges and level scaling
  // ************************************************************
  localparam logic [6:0] PARAM_MIN = 7'h00;
  localparam logic [6:0] PARAM_MAX = 7'h63;
  localparam logic [15:0] LVL_ZERO = 16'h0000;
  localparam logic [15:0] LVL_MAX = 16'hFFFF;
  // One parameter step in level units, 99 steps just under full scale
  localparam logic [15:0] LVL_STEP = 16'h0295;

  // ************************************************************
  // Rate table shape
  // ************************************************************
  localparam logic [3:0] RATE_MANT_BASE = 4'h8;
  localparam int RATE_EXP_SHIFT = 3;
  localparam logic [15:0] RATE_INSTANT = 16'hFFFF;

  // ************************************************************
  // Key tracking breakpoints, two octaves per factor of two
  // ************************************************************
  localparam logic [6:0] KEY_FAST2 = 7'h6C;
  localparam logic [6:0] KEY_FAST1 = 7'h54;
  localparam logic [6:0] KEY_SLOW1 = 7'h23;
  localparam logic [6:0] KEY_SLOW2 = 7'h0B;

endpackage

// ---- core/aeg_rate.sv ----
`timescale 1ns/1ns
module aeg_rate #(
  parameter int IW = 16
) (
  // Time setting
  input wire logic [6:0] param_i,
  // Key tracking
  input wire logic [6:0] key_i,
  input wire logic track_i,
  // Per-tick increment
  output logic [IW-1:0] inc_o
);

  // Elaboration check, the table is built for a 16-bit step
  if (IW != 16)
  begin
    $error("aeg_rate: IW must be 16");
  end

  logic [6:0] q;
  logic [17:0] base;
  logic [17:0] scaled;

  // ************************************************************
  // Exponential table: larger setting, smaller step
  // ************************************************************
  always_comb
  begin
    q = aeg_pkg::PARAM_MAX - param_i;
    if (param_i == aeg_pkg::PARAM_MIN)
      base = {2'h0, aeg_pkg::RATE_INSTANT};
    else
      base = 18'({aeg_pkg::RATE_MANT_BASE[3], q[2:0]})
             << (q >> aeg_pkg::RATE_EXP_SHIFT);
    scaled = base;
    if (track_i)
    begin
      if (key_i >= aeg_pkg::KEY_FAST2)
        scaled = base << 2;
      else if (key_i >= aeg_pkg::KEY_FAST1)
        scaled = base << 1;
      else if (key_i <= aeg_pkg::KEY_SLOW2)
        scaled = base >> 2;
      else if (key_i <= aeg_pkg::KEY_SLOW1)
        scaled = base >> 1;
    end
    if (scaled[17:16] != 2'h0)
      inc_o = aeg_pkg::RATE_INSTANT;
    else if (scaled[15:0] == 16'h0000)
      inc_o = 16'h0001;
    else
      inc_o = scaled[15:0];
  end

endmodule

// ---- dv/aeg_note_ctl.sv ----
`timescale 1ns/1ns
module aeg_note_ctl (
  // Clock
  input wire logic clk_i,
  // Key and pedal events
  output logic note_on_o,
  output logic note_off_o,
  output logic legato_o,
  output logic [6:0] key_o,
  output logic pedal_o,
  output logic mono_o
);
  initial
  begin
    note_on_o = 1'b0;
    note_off_o = 1'b0;
    legato_o = 1'b0;
    key_o = 7'h3C;
    pedal_o = 1'b0;
    mono_o = 1'b0;
  end
  // One-cycle key down pulse, launched at the falling edge
  task automatic press(input logic [6:0] k, input logic leg);
  begin
    @(negedge clk_i);
    key_o = k;
    legato_o = leg;
    note_on_o = 1'b1;
    @(negedge clk_i);
    note_on_o = 1'b0;
    legato_o = ~leg;
  end
  endtask
  // One-cycle key up pulse
  task automatic lift();
  begin
    @(negedge clk_i);
    note_off_o = 1'b1;
    @(negedge clk_i);
    note_off_o = 1'b0;
  end
  endtask
  // Pedal and keyboard mode are plain levels
  task automatic set_pedal(input logic p);
  begin
    @(negedge clk_i);
    pedal_o = p;
  end
  endtask
  task automatic set_mono(input logic m);
  begin
    @(negedge clk_i);
    mono_o = m;
  end
  endtask
endmodule

// ---- dv/aeg_core_bench.sv ----
`timescale 1ns/1ns
module aeg_core_bench;
  // ****
  // Stimulus and wiring
  // ****
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tick = 1'b0;
  logic [6:0] dly = 7'h00, atk = 7'h00, dec = 7'h00, sus = 7'h63;
  logic [6:0] sdc = 7'h63, rel = 7'h00, lvl = 7'h63;
  logic restart = 1'b0, freerun = 1'b0, track = 1'b0, pedresp = 1'b0;
  logic note_on, note_off, legato, pedal, mono;
  logic [6:0] key;
  logic [15:0] amp;
  logic [2:0] stage;
  logic active;
  int fails = 0;
  int check_count = 0;
  always #50 clk = ~clk;
  aeg_note_ctl u_aeg_note_ctl (.clk_i(clk), .note_on_o(note_on),
    .note_off_o(note_off), .legato_o(legato), .key_o(key),
    .pedal_o(pedal), .mono_o(mono));
  aeg_core u_aeg_core (.clk_i(clk), .rst_n_i(rst_n), .sample_tick_i(tick),
    .note_on_i(note_on), .note_off_i(note_off), .legato_i(legato),
    .key_i(key), .pedal_i(pedal), .mono_i(mono), .delay_i(dly),
    .attack_i(atk), .decay_i(dec), .sustain_i(sus), .sus_decay_i(sdc),
    .release_i(rel), .level_i(lvl), .restart_i(restart),
    .freerun_i(freerun), .time_track_i(track), .pedal_resp_i(pedresp),
    .amplitude_o(amp), .stage_o(stage), .active_o(active));
  // ****
  // Shared helpers
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
  begin
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  end
  endtask
  task automatic chk_st(input logic [2:0] exp);
    chk({13'h0000, stage}, {13'h0000, exp});
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic step(input int n);
    repeat (n)
    begin
      @(negedge clk);
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
    end
  endtask
  task automatic until_st(input logic [2:0] exp, input int lim);
  begin
    for (int i = 0; i < lim && stage !== exp; i++)
      step(1);
    chk_st(exp);
  end
  endtask
  task automatic cfg(input logic [6:0] d, a, dc, s, sd, r);
  begin
    dly = d;
    atk = a;
    dec = dc;
    sus = s;
    sdc = sd;
    rel = r;
  end
  endtask
  // Bring the voice back to idle with restart, run-to-completion and pedal response off; time tracking is left as it is
  task automatic home();
  begin
    cfg(7'h00, 7'h00, 7'h00, 7'h63, 7'h63, 7'h00);
    restart = 1'b0;
    freerun = 1'b0;
    pedresp = 1'b0;
    u_aeg_note_ctl.set_pedal(1'b0);
    u_aeg_note_ctl.lift();
    idle(3);
    until_st(aeg_pkg::S_IDLE, 300);
  end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_fast();
  begin
    restart = 1'b1;
    u_aeg_note_ctl.press(7'h3C, 1'b0);
    chk_st(aeg_pkg::S_ATTACK);
    chk({15'h0000, active}, 16'h0001);
    step(1);
    chk_st(aeg_pkg::S_SUSTAIN);
    idle(1);
    chk(amp, 16'hFF9E);
    step(3);
    chk(amp, 16'hFF9E);
    lvl = 7'h32;
    idle(2);
    chk(amp, 16'h8119);
    lvl = 7'h00;
    idle(2);
    chk(amp, 16'h0000);
    lvl = 7'h63;
    restart = 1'b0;
    u_aeg_note_ctl.lift();
    idle(2);
    chk_st(aeg_pkg::S_RELEASE);
    step(1);
    chk_st(aeg_pkg::S_IDLE);
    idle(1);
    chk(amp, 16'h0000);
    chk({15'h0000, active}, 16'h0000);
    $display("test fast path done");
  end
  endtask
  task automatic t_decay();
  begin
    cfg(7'h00, 7'h00, 7'h00, 7'h32, 7'h63, 7'h00);
    u_aeg_note_ctl.press(7'h3C, 1'b0);
    step(1);
    chk_st(aeg_pkg::S_DECAY);
    until_st(aeg_pkg::S_SUSTAIN, 10);
    idle(1);
    chk(amp, 16'h80E9);
    home();
    cfg(7'h00, 7'h00, 7'h00, 7'h32, 7'h00, 7'h00);
    u_aeg_note_ctl.press(7'h3C, 1'b0);
    until_st(aeg_pkg::S_SUSTAIN, 10);
    step(2);
    idle(1);
    chk(amp, 16'h0000);
    home();
    $display("test decay and sustain done");
  end
  endtask
  task automatic t_delay();
  begin
    cfg(7'h0A, 7'h00, 7'h00, 7'h63, 7'h63, 7'h00);
    u_aeg_note_ctl.press(7'h3C, 1'b0);
    chk_st(aeg_pkg::S_DELAY);
    step(1);
    chk_st(aeg_pkg::S_DELAY);
    until_st(aeg_pkg::S_ATTACK, 6);
    home();
    dly = 7'h64;
    u_aeg_note_ctl.press(7'h3C, 1'b0);
    step(20);
    chk_st(aeg_pkg::S_DELAY);
    u_aeg_note_ctl.lift();
    idle(2);
    chk_st(aeg_pkg::S_ATTACK);
    step(1);
    chk_st(aeg_pkg::S_SUSTAIN);
    until_st(aeg_pkg::S_IDLE, 10);
    home();
    $display("test delay and hold done");
  end
  endtask
  task automatic t_freerun();
  begin
    for (int m = 0; m < 2; m++)
    begin
      cfg(7'h00, 7'h32, 7'h00, 7'h63, 7'h63, 7'h00);
      restart = m[0];
      freerun = 1'b1;
      u_aeg_note_ctl.press(7'h3C, 1'b0);
      step(1);
      u_aeg_note_ctl.lift();
      idle(3);
      chk_st(aeg_pkg::S_ATTACK);
      until_st(aeg_pkg::S_SUSTAIN, 200);
      until_st(aeg_pkg::S_IDLE, 10);
      home();
    end
    $display("test run to completion done");
  end
  endtask
  task automatic t_retrig();
  begin
    cfg(7'h00, 7'h32, 7'h00, 7'h63, 7'h63, 7'h32);
    u_aeg_note_ctl.press(7'h3C, 1'b0);
    step(10);
    u_aeg_note_ctl.press(7'h40, 1'b0);
    chk_st(aeg_pkg::S_ATTACK);
    idle(1);
    chk(amp, 16'h1677);
    restart = 1'b1;
    u_aeg_note_ctl.press(7'h40, 1'b0);
    idle(2);
    chk(amp, 16'h0000);
    u_aeg_note_ctl.set_mono(1'b1);
    restart = 1'b0;
    step(5);
    u_aeg_note_ctl.lift();
    idle(2);
    u_aeg_note_ctl.press(7'h43, 1'b1);
    chk_st(aeg_pkg::S_RELEASE);
    restart = 1'b1;
    u_aeg_note_ctl.press(7'h45, 1'b1);
    chk_st(aeg_pkg::S_ATTACK);
    u_aeg_note_ctl.set_mono(1'b0);
    home();
    $display("test retrigger done");
  end
  endtask
  task automatic t_pedal();
  begin
    for (int m = 0; m < 2; m++)
    begin
      cfg(7'h00, 7'h32, 7'h00, 7'h63, 7'h32, 7'h00);
      pedresp = ~m[0];
      u_aeg_note_ctl.set_pedal(1'b1);
      u_aeg_note_ctl.press(7'h3C, 1'b0);
      step(3);
      u_aeg_note_ctl.lift();
      idle(2);
      if (m == 0)
        chk_st(aeg_pkg::S_SUSTAIN);
      else
        chk_st(aeg_pkg::S_RELEASE);
      home();
    end
    // Full level left in release, so the park must really clear it
    pedresp = 1'b1;
    rel = 7'h32;
    u_aeg_note_ctl.press(7'h3C, 1'b0);
    step(1);
    u_aeg_note_ctl.lift();
    dly = 7'h3C;
    u_aeg_note_ctl.set_pedal(1'b1);
    u_aeg_note_ctl.press(7'h3C, 1'b0);
    step(1);
    u_aeg_note_ctl.lift();
    idle(2);
    chk_st(aeg_pkg::S_PARK);
    chk(amp, 16'h0000);
    home();
    pedresp = 1'b1;
    rel = 7'h32;
    u_aeg_note_ctl.set_pedal(1'b1);
    u_aeg_note_ctl.press(7'h3C, 1'b0);
    step(1);
    u_aeg_note_ctl.lift();
    idle(2);
    chk_st(aeg_pkg::S_RELEASE);
    home();
    $display("test pedal done");
  end
  endtask
  // Setting 50 steps 0x240 a tick: x4 at key 108, /2 at key 35
  task automatic t_track();
  begin
    cfg(7'h00, 7'h32, 7'h00, 7'h63, 7'h63, 7'h32);
    track = 1'b1;
    u_aeg_note_ctl.press(7'h6C, 1'b0);
    step(113);
    chk_st(aeg_pkg::S_ATTACK);
    step(1);
    chk_st(aeg_pkg::S_SUSTAIN);
    u_aeg_note_ctl.lift();
    idle(2);
    step(28);
    chk_st(aeg_pkg::S_RELEASE);
    step(1);
    chk_st(aeg_pkg::S_IDLE);
    atk = 7'h00;
    u_aeg_note_ctl.press(7'h23, 1'b0);
    step(1);
    u_aeg_note_ctl.lift();
    idle(2);
    step(227);
    chk_st(aeg_pkg::S_RELEASE);
    step(1);
    chk_st(aeg_pkg::S_IDLE);
    track = 1'b0;
    home();
    $display("test time tracking done");
  end
  endtask
  // ****
  // Run control
  // ****
  task automatic give_verdict();
  begin
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  initial
  begin
    #(100 * 40000);
    fails++;
    $display("BAD %0t run did not finish", $time);
    give_verdict();
  end
  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    idle(2);
    chk_st(aeg_pkg::S_IDLE);
    t_fast();
    t_decay();
    t_delay();
    t_freerun();
    t_retrig();
    t_pedal();
    t_track();
    give_verdict();
  end
endmodule
